// ===== dv/csc_osc_model.sv
`timescale 1ns/1ps
`include "csc_params.svh"
// ************************************************
// Oscillator sources seen from the switch control.
// ************************************************
module csc_osc_model #(
  parameter int EXT_DLY = 20,
  parameter int INT_DLY = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`CSC_NUM_OSC-1:0] en,
  input wire logic [3:0] frq,
  output logic [`CSC_NUM_OSC-1:0] rdy
);
  logic [7:0] cnt [`CSC_NUM_OSC];
  logic [3:0] frq_q;

  // The internal pair always runs but restarts its settling on a new frequency.
  always @(posedge clk) begin
    frq_q <= frq;
    for (int i = 0; i < `CSC_NUM_OSC; i++) begin
      if (!rst_n || (!en[i] && i != 1 && i != 2) || ((i == 1 || i == 2) && frq !== frq_q)) begin
        cnt[i] <= 8'h00;
      end else if (cnt[i] < ((i == 0) ? EXT_DLY : INT_DLY)) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `CSC_NUM_OSC; i++) begin
      rdy[i] = (cnt[i] >= ((i == 0) ? EXT_DLY : INT_DLY));
    end
  end
endmodule

// ===== dv/system_clock_switch_control_bench.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module system_clock_switch_control_bench;
  import csc_pkg::*;
  logic clock, rst_n, rd_e, wr_e, wait_r, cfg_en, cpu_run, doze, sleep;
  logic mf_stall, sys_clk, sys_tick, irq;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [`CSC_NUM_OSC-1:0] osc_rdy, osc_en;
  logic [3:0] frq_sel, cur_div;
  logic [2:0] cur_src;
  int n_fail, total_checks, cyc, n_per, n_hi;

  csc_top DUT (.CLOCK(clock), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd_e), .AVS_WRITE(wr_e),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r),
    .OSC_READY(osc_rdy), .CFG_SWITCH_EN(cfg_en), .CPU_RUN(cpu_run), .DOZE_ACTIVE(doze),
    .SLEEP_ACTIVE(sleep), .OSC_ENABLE(osc_en), .FREQ_SELECT(frq_sel), .MF_STALL(mf_stall),
    .CUR_SOURCE(cur_src), .CUR_DIVIDER(cur_div), .SYS_CLK(sys_clk), .SYS_TICK(sys_tick), .SWITCH_IRQ(irq));

  csc_osc_model osc (.clk(clock), .rst_n(rst_n), .en(osc_en), .frq(frq_sel), .rdy(osc_rdy));

  // ************************************************
  // Bus access, comparison and closing.
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr_e <= 1'b1;
    addr <= {a, 2'b00};
    wdata <= {24'h0, d};
    do @(posedge clock); while (wait_r);
    wr_e <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clock);
    rd_e <= 1'b1;
    addr <= {a, 2'b00};
    do @(posedge clock); while (wait_r);
    rv = rdata;
    rd_e <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ************************************************
  // Test sequence.
  // ************************************************
  initial begin
    rst_n = 1'b0; rd_e = 1'b0; wr_e = 1'b0; addr = 5'h00; wdata = 32'h0; cfg_en = 1'b1;
    cpu_run = 1'b1; doze = 1'b0; sleep = 1'b0; n_fail = 0; total_checks = 0; cyc = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`CSC_A_CUR); chk(rv, 32'h60);
    rd(`CSC_A_CTL); chk(rv, 32'h10);
    chk(cur_src, 3'h6);
    $display("reset test done");
    wr(`CSC_A_IEN, 8'h01);
    wr(`CSC_A_REQ, 8'h70);
    rd(`CSC_A_CTL); chk(rv, 32'h00);
    chk(cur_src, 3'h6);
    for (int i = 0; i < 300 && cur_src !== 3'h7; i++) @(posedge clock);
    chk(cur_src, 3'h7);
    rd(`CSC_A_CTL); chk(rv, 32'h10);
    rd(`CSC_A_FLAG); chk(rv, 32'h01);
    chk(irq, 1'b1);
    wr(`CSC_A_FLAG, 8'h01);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    $display("source switch test done");
    wr(`CSC_A_IEN, 8'h00);
    wr(`CSC_A_CTL, 8'h80);
    wr(`CSC_A_REQ, 8'h63);
    repeat (10) @(posedge clock);
    rd(`CSC_A_CTL); chk(rv, 32'h88);
    chk(cur_src, 3'h7);
    chk(irq, 1'b0);
    wr(`CSC_A_FLAG, 8'h01);
    wr(`CSC_A_CTL, 8'h00);
    for (int i = 0; i < 50 && cur_src !== 3'h6; i++) @(posedge clock);
    chk({cur_src, cur_div}, 7'h63);
    $display("hold test done");
    wr(`CSC_A_CTL, 8'h80);
    wr(`CSC_A_REQ, 8'h75);
    repeat (60) @(posedge clock);
    rd(`CSC_A_CTL); chk(rv & 32'h08, 32'h08);
    wr(`CSC_A_REQ, 8'h63);
    rd(`CSC_A_CTL); chk(rv & 32'h08, 32'h00);
    repeat (5) @(posedge clock);
    chk({cur_src, cur_div}, 7'h63);
    wr(`CSC_A_CTL, 8'h00);
    wr(`CSC_A_FLAG, 8'h01);
    $display("abandon test done");
    wr(`CSC_A_IEN, 8'h01);
    cpu_run <= 1'b0;
    sleep <= 1'b1;
    wr(`CSC_A_REQ, 8'h65);
    repeat (10) @(posedge clock);
    chk(cur_div, 4'h3);
    chk(irq, 1'b0);
    doze <= 1'b1;
    repeat (3) @(posedge clock);
    chk(cur_div, 4'h5);
    sleep <= 1'b0;
    cpu_run <= 1'b1;
    doze <= 1'b0;
    repeat (3) @(posedge clock);
    chk(irq, 1'b1);
    wr(`CSC_A_FLAG, 8'h01);
    $display("sleep and slowdown test done");
    cfg_en <= 1'b0;
    repeat (4) @(posedge clock);
    wr(`CSC_A_REQ, 8'h70);
    rd(`CSC_A_REQ); chk(rv, 32'h65);
    repeat (40) @(posedge clock);
    chk(cur_src, 3'h6);
    cfg_en <= 1'b1;
    while (sys_tick !== 1'b1) @(posedge clock);
    n_per = 0;
    n_hi = 0;
    do begin
      @(posedge clock);
      n_per++;
      if (sys_clk === 1'b1) n_hi++;
    end while (sys_tick !== 1'b1 && n_per < 100);
    chk(n_per, 32);
    chk(n_hi, 16);
    $display("switch enable test done");
    wr(`CSC_A_FRQ, 8'h05);
    rd(`CSC_A_STAT); chk(rv & 32'h06, 32'h00);
    chk({mf_stall, frq_sel}, 5'h15);
    for (int i = 0; i < 100 && mf_stall !== 1'b0; i++) @(posedge clock);
    repeat (5) @(posedge clock);
    rd(`CSC_A_STAT); chk(rv & 32'h06, 32'h06);
    chk(mf_stall, 1'b0);
    $display("frequency select test done");
    wr(`CSC_A_REQ, 8'h35);
    rd(`CSC_A_REQ); chk(rv, 32'h65);
    wr(`CSC_A_MEN, 8'h18);
    repeat (2) @(posedge clock);
    chk(osc_en & 5'h18, 5'h18);
    repeat (20) @(posedge clock);
    rd(`CSC_A_STAT); chk(rv & 32'h18, 32'h18);
    $display("manual enable test done");
    report_and_stop();
  end
endmodule

// ===== hdl/csc_clk_div.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_clk_div
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  csc_div_if.divr dif,
  output logic sys_clk,
  output logic sys_tick
);
  csc_div_s q, d;
  logic [3:0] use_div;

  // *****************************************************************
  // A new divider is only taken at a period boundary, so no phase is cut short.
  // *****************************************************************
  always_comb begin
    d = q;
    d.tick = 1'b0;
    use_div = q.pend ? q.pdiv : q.div;
    if (dif.load) begin
      d.pend = 1'b1;
      d.pdiv = dif.div;
    end
    if (q.cnt == '0) begin
      d.div = use_div;
      d.pend = dif.load;
      d.cnt = `CSC_CNT_W'((1 << use_div) - 1);
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt - `CSC_CNT_W'(1);
    end
    d.clk = (d.cnt >= `CSC_CNT_W'((1 << d.div) >> 1));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '{cnt: '0, div: `CSC_DIV_RST, pdiv: `CSC_DIV_RST, pend: 1'b0, clk: 1'b1, tick: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign dif.applied = q.tick & ~q.pend;
  assign sys_clk = q.clk;
  assign sys_tick = q.tick;
endmodule

// ===== hdl/csc_div_if.sv
`timescale 1ns/1ps
interface csc_div_if;
  logic load;
  logic [3:0] div;
  logic applied;
  modport ctrl (output load, output div, input applied);
  modport divr (input load, input div, output applied);
endinterface

// ===== hdl/csc_params.svh
// How it works
// - Every oscillator ready shows in status; all five can be forced on.
// - Internal oscillators stay usable; ready flags only mark accurate frequency.
// - Writing frequency select clears both internal ready flags until ready again.
// - Mid-frequency clock stalls while a frequency select change is pending.
// - Software picks system source, external or internal block, via new source field.
// - Old clock keeps running until requested source reports stable and ready.
// - Source already running, or divider-only change, counts as ready at once.
// - Sleep may be entered while a switch still waits for its source.
// - New source ready sets the ready bit and the switch done flag.
// - Switch interrupt raised only when its enable bit is 1.
// - Switch interrupt never wakes the system from sleep.
// - Hold clear: switch happens as soon as new source ready sets, while the CPU runs or slowdown mode is on.
// - Hold set: switch suspended, old clock kept even when new source ready.
// - In slowdown mode the switch occurs next cycle, CPU running or not.
// - Divider-only change uses the same procedure and needs hold at 0.
// - Current clock register updates at the switch and sets oscillator ready.
// - Hardware clears new source ready once the switch has completed.
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_NUM_OSC 5
`define CSC_OSC_EXT 0
`define CSC_OSC_HF 1
`define CSC_OSC_MF 2
`define CSC_OSC_CFG 5
`define CSC_SRC_EXT 3'h7
`define CSC_SRC_INT 3'h6
`define CSC_SRC_RST 3'h6
`define CSC_DIV_RST 4'h0
`define CSC_DIV_MAX 4'h9
`define CSC_FRQ_RST 4'h2
`define CSC_CNT_W 9
`define CSC_A_REQ 3'h0
`define CSC_A_CUR 3'h1
`define CSC_A_CTL 3'h2
`define CSC_A_STAT 3'h3
`define CSC_A_MEN 3'h4
`define CSC_A_FRQ 3'h5
`define CSC_A_FLAG 3'h6
`define CSC_A_IEN 3'h7
`define CSC_B_HOLD 7
`define CSC_B_OSC_READY_BIT 4
`define CSC_B_NOSR 3
`define CSC_B_SWIF 0
`define CSC_B_SWIE 0
`endif

// ===== hdl/csc_pkg.sv
`include "csc_params.svh"
package csc_pkg;
  typedef enum logic [1:0] {
    CSC_IDLE = 2'b00,
    CSC_WAIT = 2'b01,
    CSC_RDY = 2'b10
  } csc_state_e;

  typedef struct packed {
    csc_state_e st;
    logic [2:0] cur_src;
    logic [3:0] cur_div;
    logic [2:0] new_src;
    logic [3:0] new_div;
    logic hold;
    logic nosr;
    logic osc_ready_bit;
    logic swif;
    logic swie;
    logic irq;
    logic [`CSC_NUM_OSC-1:0] man_en;
    logic [`CSC_NUM_OSC-1:0] osc_en;
    logic [3:0] frq;
    logic frq_pend;
    logic frq_low;
    logic hf_rdy;
    logic mf_rdy;
    logic ack;
    logic load;
    logic [31:0] rdata;
  } csc_main_s;

  typedef struct packed {
    logic [`CSC_CNT_W-1:0] cnt;
    logic [3:0] div;
    logic [3:0] pdiv;
    logic pend;
    logic clk;
    logic tick;
  } csc_div_s;

  typedef struct packed {
    logic [`CSC_NUM_OSC:0] s1;
    logic [`CSC_NUM_OSC:0] s2;
  } csc_sync_s;
endpackage

// ===== hdl/csc_sync.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_sync
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`CSC_NUM_OSC:0] din,
  output logic [`CSC_NUM_OSC:0] dout
);
  csc_sync_s q, d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// ===== hdl/csc_top.sv
`timescale 1ns/1ps
`include "csc_params.svh"
module csc_top
  import csc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [`CSC_NUM_OSC-1:0] OSC_READY,
  input wire logic CFG_SWITCH_EN,
  input wire logic CPU_RUN,
  input wire logic DOZE_ACTIVE,
  input wire logic SLEEP_ACTIVE,
  output logic [`CSC_NUM_OSC-1:0] OSC_ENABLE,
  output logic [3:0] FREQ_SELECT,
  output logic MF_STALL,
  output logic [2:0] CUR_SOURCE,
  output logic [3:0] CUR_DIVIDER,
  output logic SYS_CLK,
  output logic SYS_TICK,
  output logic SWITCH_IRQ
);
  import csc_pkg::*;

  csc_main_s q, d;
  logic [`CSC_NUM_OSC:0] pins_s;
  logic [`CSC_NUM_OSC-1:0] rdy_s;
  logic cfg_en_s;
  logic wr, wr0, new_rdy, clr_swif, set_swif;
  logic [2:0] widx;
  csc_div_if dif ();

  // *****************************************************************
  // OSC_READY and CFG_SWITCH_EN pass two flip-flops.
  // *****************************************************************
  csc_sync u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .din({CFG_SWITCH_EN, OSC_READY}),
    .dout(pins_s)
  );
  assign rdy_s = pins_s[`CSC_NUM_OSC-1:0];
  assign cfg_en_s = pins_s[`CSC_OSC_CFG];

  csc_clk_div u_div (
    .clk(CLOCK),
    .rst_n(RST_N),
    .dif(dif.divr),
    .sys_clk(SYS_CLK),
    .sys_tick(SYS_TICK)
  );
  assign dif.load = q.load;
  assign dif.div = q.cur_div;

  function automatic int unsigned osc_of(input logic [2:0] src);
    osc_of = (src == `CSC_SRC_EXT) ? `CSC_OSC_EXT : `CSC_OSC_HF;
  endfunction

  // *****************************************************************
  // Avalon slave: one wait state, writes and read data at the ack edge.
  // *****************************************************************
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~q.ack;
  assign widx = AVS_ADDRESS[4:2];
  assign wr = AVS_WRITE & q.ack;
  assign wr0 = wr & AVS_BYTEENABLE[0];
  assign new_rdy = (q.new_src == q.cur_src) || rdy_s[osc_of(q.new_src)];
  assign clr_swif = wr0 && widx == `CSC_A_FLAG && AVS_WRITEDATA[`CSC_B_SWIF];
  assign set_swif = (q.st == CSC_WAIT) && new_rdy;

  always_comb begin
    d = q;
    d.ack = (AVS_READ | AVS_WRITE) & ~q.ack;
    d.load = 1'b0;
    d.rdata = '0;

    // *****************************************************************
    // Read data for the addressed word.
    // *****************************************************************
    unique case (widx)
      `CSC_A_REQ: d.rdata[6:0] = {q.new_src, q.new_div};
      `CSC_A_CUR: d.rdata[6:0] = {q.cur_src, q.cur_div};
      `CSC_A_CTL: d.rdata[`CSC_B_HOLD:0] = {q.hold, 2'b00, q.osc_ready_bit, q.nosr, 3'b000};
      `CSC_A_STAT: d.rdata[`CSC_NUM_OSC-1:0] = {rdy_s[4:3], q.mf_rdy, q.hf_rdy, rdy_s[0]};
      `CSC_A_MEN: d.rdata[`CSC_NUM_OSC-1:0] = q.man_en;
      `CSC_A_FRQ: d.rdata[3:0] = q.frq;
      `CSC_A_FLAG: d.rdata[`CSC_B_SWIF] = q.swif;
      `CSC_A_IEN: d.rdata[`CSC_B_SWIE] = q.swie;
    endcase

    // *****************************************************************
    // Frequency select tracking.
    // *****************************************************************
    // Internal ready flags track accuracy; the clocks keep running, but MF_STALL stalls the mid clock while pending.
    if (q.frq_pend) begin
      if (!rdy_s[`CSC_OSC_HF]) begin
        d.frq_low = 1'b1;
      end
      if (q.frq_low && rdy_s[`CSC_OSC_HF]) begin
        d.frq_pend = 1'b0;
      end
      d.hf_rdy = 1'b0;
      d.mf_rdy = 1'b0;
    end else begin
      d.hf_rdy = rdy_s[`CSC_OSC_HF];
      d.mf_rdy = rdy_s[`CSC_OSC_MF];
    end

    // *****************************************************************
    // Clock switch sequencer.
    // *****************************************************************
    // Switch sequencer; it waits through sleep as well.
    unique case (q.st)
      CSC_IDLE: begin
      end
      CSC_WAIT: begin
        if (new_rdy) begin
          d.nosr = 1'b1;
          d.st = CSC_RDY;
        end
      end
      CSC_RDY: begin
        if (!q.hold && (CPU_RUN || DOZE_ACTIVE)) begin
          d.cur_src = q.new_src;
          d.cur_div = q.new_div;
          d.osc_ready_bit = 1'b1;
          d.nosr = 1'b0;
          d.load = 1'b1;
          d.st = CSC_IDLE;
        end
      end
      default: d.st = CSC_IDLE;
    endcase
    d.swif = (q.swif & ~clr_swif) | set_swif;

    // *****************************************************************
    // Register writes.
    // *****************************************************************
    if (wr0) begin
      unique case (widx)
        `CSC_A_REQ: begin
          if (cfg_en_s && AVS_WRITEDATA[6:4] inside {`CSC_SRC_EXT, `CSC_SRC_INT}
              && AVS_WRITEDATA[3:0] <= `CSC_DIV_MAX) begin
            d.new_src = AVS_WRITEDATA[6:4];
            d.new_div = AVS_WRITEDATA[3:0];
            // A switch taken in this same cycle keeps its divider load.
            if (AVS_WRITEDATA[6:0] == {q.cur_src, q.cur_div} && q.st != CSC_IDLE) begin
              d.st = CSC_IDLE;
              d.nosr = 1'b0;
            end else if (AVS_WRITEDATA[6:0] != {q.new_src, q.new_div} || q.st == CSC_IDLE) begin
              d.st = CSC_WAIT;
              d.nosr = 1'b0;
              d.osc_ready_bit = 1'b0;
              d.cur_src = q.cur_src;
              d.cur_div = q.cur_div;
            end
          end
        end
        `CSC_A_CTL: d.hold = AVS_WRITEDATA[`CSC_B_HOLD];
        `CSC_A_MEN: d.man_en = AVS_WRITEDATA[`CSC_NUM_OSC-1:0];
        `CSC_A_FRQ: begin
          d.frq = AVS_WRITEDATA[3:0];
          d.frq_pend = 1'b1;
          d.frq_low = 1'b0;
          d.hf_rdy = 1'b0;
          d.mf_rdy = 1'b0;
        end
        `CSC_A_IEN: d.swie = AVS_WRITEDATA[`CSC_B_SWIE];
        default: begin
        end
      endcase
    end

    // *****************************************************************
    // Oscillator enables and interrupt.
    // *****************************************************************
    d.osc_en = d.man_en;
    d.osc_en[osc_of(d.cur_src)] = 1'b1;
    if (d.st != CSC_IDLE) begin
      d.osc_en[osc_of(d.new_src)] = 1'b1;
    end
    d.irq = d.swif & d.swie & ~SLEEP_ACTIVE;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      q <= '0;
      q.cur_src <= `CSC_SRC_RST;
      q.new_src <= `CSC_SRC_RST;
      q.cur_div <= `CSC_DIV_RST;
      q.new_div <= `CSC_DIV_RST;
      q.frq <= `CSC_FRQ_RST;
      q.osc_ready_bit <= 1'b1;
      q.osc_en <= `CSC_NUM_OSC'(1 << `CSC_OSC_HF);
    end else begin
      q <= d;
    end
  end

  assign AVS_READDATA = q.rdata;
  assign OSC_ENABLE = q.osc_en;
  assign FREQ_SELECT = q.frq;
  assign MF_STALL = q.frq_pend;
  assign CUR_SOURCE = q.cur_src;
  assign CUR_DIVIDER = q.cur_div;
  assign SWITCH_IRQ = q.irq;

  // *****************************************************************
  // Assertions.
  // *****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  ready_flag_a: assert property ((q.st == CSC_WAIT && new_rdy && !wr0) |=> q.nosr && q.swif)
    else $error("ready bit or flag not set");
  hold_keep_a: assert property ((q.st == CSC_RDY && q.hold && !wr0) |=> $stable(q.cur_src) && q.st == CSC_RDY)
    else $error("switch taken while held");
  go_now_a: assert property ((q.st == CSC_RDY && !q.hold && (CPU_RUN || DOZE_ACTIVE) && !wr0)
    |=> q.st == CSC_IDLE && !q.nosr && q.osc_ready_bit)
    else $error("switch not taken");
  doze_go_a: assert property ((q.st == CSC_RDY && !q.hold && DOZE_ACTIVE && !CPU_RUN && !wr0)
    |=> q.load)
    else $error("doze switch late");
  cur_hold_a: assert property ((q.st == CSC_WAIT) |=> $stable(q.cur_src) && $stable(q.cur_div))
    else $error("current changed early");
  irq_gate_a: assert property (SWITCH_IRQ |-> q.swie && !$past(SLEEP_ACTIVE))
    else $error("irq without enable");
  sleep_quiet_a: assert property (SLEEP_ACTIVE |=> !SWITCH_IRQ)
    else $error("irq during sleep");
  frq_clear_a: assert property ((wr0 && widx == `CSC_A_FRQ) |=> !q.hf_rdy && !q.mf_rdy && MF_STALL)
    else $error("freq flags not cleared");
  cfg_block_a: assert property ((wr0 && widx == `CSC_A_REQ && !cfg_en_s) |=> $stable(q.new_src)
    && $stable(q.new_div))
    else $error("request accepted while disabled");
  div_only_a: assert property ((q.st == CSC_WAIT && q.new_src == q.cur_src && !wr0) |=> q.st == CSC_RDY)
    else $error("divider change not ready");
  flag_win_a: assert property ((set_swif && clr_swif) |=> q.swif)
    else $error("flag set lost");
  ack_once_a: assert property ((AVS_READ || AVS_WRITE) && !q.ack |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  forced_on_a: assert property (q.osc_en == (q.osc_en | q.man_en))
    else $error("manual enable lost");

  // *****************************************************************
  // Switch sequencer checks.
  // *****************************************************************
  nosr_match_a: assert property (q.nosr == (q.st == CSC_RDY))
    else $error("ready bit out of step");
  pend_osc_ready_bit_a: assert property ((q.st != CSC_IDLE) |-> !q.osc_ready_bit)
    else $error("osc ready while pending");
  cur_load_a: assert property (($changed(q.cur_src) || $changed(q.cur_div)) |-> q.load)
    else $error("current changed without load");
  cur_osc_a: assert property (q.osc_en[osc_of(q.cur_src)])
    else $error("current oscillator off");
  new_osc_a: assert property ((q.st != CSC_IDLE) |-> q.osc_en[osc_of(q.new_src)])
    else $error("requested oscillator off");
  sleep_wait_a: assert property ((q.st == CSC_WAIT && SLEEP_ACTIVE && new_rdy && !wr0)
    |=> q.st == CSC_RDY)
    else $error("wait stalled in sleep");
  run_gate_a: assert property ((q.st == CSC_RDY && !CPU_RUN && !DOZE_ACTIVE && !wr0)
    |=> q.st == CSC_RDY && $stable(q.cur_div))
    else $error("switch without cpu clock");
  irq_set_a: assert property ((q.swif && q.swie && !SLEEP_ACTIVE && !clr_swif
    && !(wr0 && widx == `CSC_A_IEN)) |=> SWITCH_IRQ)
    else $error("irq missing");

  // *****************************************************************
  // Frequency select and register write checks.
  // *****************************************************************
  stall_end_a: assert property ((q.frq_pend && q.frq_low && rdy_s[`CSC_OSC_HF] && !wr0) |=> !MF_STALL)
    else $error("mid clock stall not released");
  flag_follow_a: assert property ((!q.frq_pend && !wr0)
    |=> q.hf_rdy == $past(rdy_s[`CSC_OSC_HF]) && q.mf_rdy == $past(rdy_s[`CSC_OSC_MF]))
    else $error("ready flag not following");
  hold_write_a: assert property ((wr0 && widx == `CSC_A_CTL)
    |=> q.hold == $past(AVS_WRITEDATA[`CSC_B_HOLD]))
    else $error("hold bit not written");
  src_check_a: assert property ((wr0 && widx == `CSC_A_REQ
    && !(AVS_WRITEDATA[6:4] inside {`CSC_SRC_EXT, `CSC_SRC_INT})) |=> $stable({q.new_src, q.new_div}))
    else $error("bad source accepted");
  new_req_a: assert property ((wr0 && widx == `CSC_A_REQ && cfg_en_s
    && AVS_WRITEDATA[6:4] inside {`CSC_SRC_EXT, `CSC_SRC_INT} && AVS_WRITEDATA[3:0] <= `CSC_DIV_MAX)
    |=> {q.new_src, q.new_div} == $past(AVS_WRITEDATA[6:0]))
    else $error("request not taken");
  abandon_a: assert property ((wr0 && widx == `CSC_A_REQ && cfg_en_s && q.st != CSC_IDLE
    && AVS_WRITEDATA[6:0] == {q.cur_src, q.cur_div}) |=> q.st == CSC_IDLE && !q.nosr)
    else $error("abandon not taken");

  // *****************************************************************
  // Bus handshake checks.
  // *****************************************************************
  ack_pulse_a: assert property (q.ack |=> !q.ack)
    else $error("bus answer held");

  // *****************************************************************
  // Cover points.
  // *****************************************************************
  switch_c: cover property (q.st == CSC_RDY ##1 q.load);
  applied_c: cover property (dif.applied);
  held_c: cover property (q.st == CSC_RDY && q.hold [*3] ##1 !q.hold);
  abandon_c: cover property (q.st == CSC_RDY ##1 q.st == CSC_IDLE && !q.load);
  frq_c: cover property (MF_STALL ##[1:50] !MF_STALL);
endmodule
